// file: design/gpio_interrupt_and_led_select.sv
module gpio_interrupt_and_led_select
  import pin_irq_led_pkg::*;
#(
  parameter int PINS    = 12,
  parameter int LEDS    = 8,
  parameter int BLINK_N = BLINK_DIV
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rdata,
  // Straps and loader override
  input  wire logic [1:0]        indication_select_strap,
  input  wire logic [7:0]        pin_select_strap,
  input  wire logic              loader_valid,
  input  wire logic [1:0]        loader_indication,
  input  wire logic [7:0]        loader_pin_select,
  // Pins and LED sources
  input  wire logic [PINS-1:0]   pin_in,
  input  wire logic [LEDS-1:0]   led_link,
  input  wire logic [LEDS-1:0]   led_activity,
  input  wire logic [LEDS-1:0]   gpio_out,
  output logic      [LEDS-1:0]   pin_out,
  output logic      [LEDS-1:0]   led_mode,
  // Interrupts
  output logic                   irq
);
  // Synchroniser, polarity and filter
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] polarity;
  logic [PINS-1:0] next_polarity;
  logic [PINS-1:0] active;
  logic [PINS-1:0] pin_event;

  // Pin interrupt state
  logic [PINS-1:0] status;
  logic [PINS-1:0] next_status;
  logic [PINS-1:0] clear_mask;
  logic [PINS-1:0] enable;
  logic [PINS-1:0] next_enable;
  logic            sys_pin_enable;
  logic            next_sys_pin_enable;
  logic            sys_status;
  logic            next_sys_status;
  logic            pin_summary;

  // LED configuration
  logic [7:0]      led_pin_select;
  logic [7:0]      next_pin_select;
  logic [1:0]      led_indication_select;
  logic [1:0]      next_indication;
  logic            strap_pending;
  logic            next_strap_pending;

  // Register port decode
  logic            wr_led_pin_configuration;
  logic            wr_pin_irq;
  logic            wr_sys_enable;
  logic            wr_pin_pol;
  logic            rd_sys_status;
  logic [31:0]     next_rdata;

  // Blink divider and LED drive
  logic [31:0]     blink_count;
  logic            blink_tick;
  logic            blink;
  logic [LEDS-1:0] indication;
  logic [LEDS-1:0] next_pin_out;

  // Full-address compare used by every decode; a partial decode would
  // alias registers onto unmapped offsets that must read as zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] offset);
    reg_hit = (a == offset);
  endfunction

  // Pins come from outside the clock domain: two flip-flops first.
  // Only sync2 is read downstream; sync1 may be metastable for a cycle.
  // Costs two cycles of latency before the glitch filter starts counting.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // Active level per pin follows the polarity register.
  // Reset polarity is all ones, so a high pin is active by default;
  // software flips a bit to treat a low level as the active one.
  assign active = ~(sync2 ^ polarity);

  // One glitch filter per pin. Each restarts on any gap, so bounces never
  // add up across separate short pulses into a false event.
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_filter
      pin_level_filter #(
        .HOLD (MIN_PULSE_CYC)
      ) u_filter (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .level       (active[i]),
        .event_pulse (pin_event[i])
      );
    end
  endgenerate

  // Address decode: full compare, so aliases of a register read as unmapped
  assign wr_led_pin_configuration    = wr_en && reg_hit(addr, LED_PIN_CONFIGURATION_OFFSET);
  assign wr_pin_irq    = wr_en && reg_hit(addr, PIN_IRQ_OFFSET);
  assign wr_sys_enable = wr_en && reg_hit(addr, SYS_ENABLE_OFFSET);
  assign wr_pin_pol    = wr_en && reg_hit(addr, PIN_POL_OFFSET);
  assign rd_sys_status = rd_en && reg_hit(addr, SYS_STATUS_OFFSET);

  // Write-one-to-clear mask; zero bits in the write leave status alone
  assign clear_mask = wr_pin_irq ? wdata[STATUS_LSB +: PINS] : '0;

  // Events are ORed in after the clear, so an event in the same cycle as
  // its clear survives and no interrupt is lost; the enable is not used
  // here on purpose, a disabled pin still records its events
  assign next_status = (status & ~clear_mask) | pin_event;

  // Per-pin status register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Enables take the upper half of a write to the status and enable word;
  // the status half of the same write only clears, it never sets
  always_comb begin
    next_enable = enable;
    if (wr_pin_irq) begin
      next_enable = wdata[ENABLE_LSB +: PINS];
    end
  end

  // Per-pin enables reset to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable <= ENABLE_RESET;
    end else begin
      enable <= next_enable;
    end
  end

  // Polarity so either level may be the active one. Changing it while a
  // pin is steady can raise an event once the filter has seen the new level.
  always_comb begin
    next_polarity = polarity;
    if (wr_pin_pol) begin
      next_polarity = wdata[PINS-1:0];
    end
  end

  // Polarity register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      polarity <= POL_RESET;
    end else begin
      polarity <= next_polarity;
    end
  end

  // Enabled status bits fold into one system status bit; a disabled pin
  // keeps its status but no longer holds the summary up
  assign pin_summary = |(status & enable);

  // System status bit 12 is sticky and cleared by its read; the summary
  // wins over a same-cycle read so a pending source keeps the bit up
  always_comb begin
    next_sys_status = sys_status;
    if (pin_summary) begin
      next_sys_status = 1'b1;
    end else if (rd_sys_status) begin
      next_sys_status = 1'b0;
    end
  end

  // System status register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_status <= 1'b0;
    end else begin
      sys_status <= next_sys_status;
    end
  end

  // System enable mask of the same layout; other bits are not stored
  always_comb begin
    next_sys_pin_enable = sys_pin_enable;
    if (wr_sys_enable) begin
      next_sys_pin_enable = wdata[SYS_PIN_BIT];
    end
  end

  // System enable register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_pin_enable <= 1'b0;
    end else begin
      sys_pin_enable <= next_sys_pin_enable;
    end
  end

  // Level interrupt needs both the system and per-pin enables. It comes
  // straight from two flops, so it cannot glitch between clock edges; a
  // read that clears the status drops it in the following cycle.
  assign irq = sys_status && sys_pin_enable;

  // Straps are caught by the first clock after reset release, then the
  // loader may overwrite them as new defaults; a host write in that first
  // cycle is lost, and the loader beats a host write in the same cycle
  always_comb begin
    next_strap_pending = 1'b0;
    next_pin_select    = led_pin_select;
    next_indication    = led_indication_select;
    if (strap_pending) begin
      next_pin_select = pin_select_strap;
      next_indication = indication_select_strap;
    end else if (loader_valid) begin
      next_pin_select = loader_pin_select;
      next_indication = loader_indication;
    end else if (wr_led_pin_configuration) begin
      next_pin_select = wdata[SELECT_LSB +: 8];
      next_indication = wdata[INDICATION_LSB +: 2];
    end
  end

  // Strap capture flag, set by reset and dropped after one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= next_strap_pending;
    end
  end

  // Pin-select field; all pins stay general purpose until the straps land
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_pin_select <= '0;
    end else begin
      led_pin_select <= next_pin_select;
    end
  end

  // Indication field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_indication_select <= '0;
    end else begin
      led_indication_select <= next_indication;
    end
  end

  // Divider count; the slow rate leaves it only as a one-cycle tick.
  // The count is wide enough for the default divide of five million.
  always_ff @(posedge clk) begin
    if (sys_rst || blink_tick) begin
      blink_count <= '0;
    end else begin
      blink_count <= blink_count + 32'h0000_0001;
    end
  end

  // One-cycle enable at the end of each divider period
  assign blink_tick = (blink_count == 32'(BLINK_N - 1));

  // Blink level flips on each tick; it is shared by all LED pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink <= 1'b0;
    end else if (blink_tick) begin
      blink <= ~blink;
    end
  end

  // Indication chosen by the two-bit function field; code 3 keeps it dark
  always_comb begin
    case (indication_t'(led_indication_select))
      IND_LINK:  indication = led_link;
      IND_ACT:   indication = led_link & ~led_activity;
      IND_BLINK: indication = led_link & {LEDS{blink}};
      default:   indication = '0;
    endcase
  end

  // Function applies only on LED-selected pins; others carry GPIO data.
  // Per-bit mux, so re-selecting one pin never disturbs its neighbours.
  assign next_pin_out = (indication & led_pin_select) | (gpio_out & ~led_pin_select);

  // Registered pin drive and mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out  <= '0;
      led_mode <= '0;
    end else begin
      pin_out  <= next_pin_out;
      led_mode <= led_pin_select;
    end
  end

  // Read mux, unmapped addresses read zero; reserved bits read zero too
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_hit(addr, PIN_IRQ_OFFSET)) begin
      next_rdata[ENABLE_LSB +: PINS] = enable;
      next_rdata[STATUS_LSB +: PINS] = status;
    end else if (reg_hit(addr, LED_PIN_CONFIGURATION_OFFSET)) begin
      next_rdata[INDICATION_LSB +: 2] = led_indication_select;
      next_rdata[SELECT_LSB +: 8]     = led_pin_select;
    end else if (reg_hit(addr, SYS_STATUS_OFFSET)) begin
      next_rdata[SYS_PIN_BIT] = sys_status;
    end else if (reg_hit(addr, SYS_ENABLE_OFFSET)) begin
      next_rdata[SYS_PIN_BIT] = sys_pin_enable;
    end else if (reg_hit(addr, PIN_POL_OFFSET)) begin
      next_rdata[PINS-1:0] = polarity;
    end
  end

  // Read data stands one cycle after the strobe only, zero otherwise,
  // so a stale word can never be mistaken for a fresh answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end
endmodule

// file: design/pin_level_filter.sv
// Qualifies one active-high pin level; fires once when it lasts long enough
module pin_level_filter
  import pin_irq_led_pkg::*;
#(
  parameter int HOLD = MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Synchronised active level
  input  wire logic level,
  // One-cycle event
  output logic      event_pulse
);
  logic [3:0] count;
  logic       fired;

  // Count consecutive active cycles; shorter pulses restart the count
  always_ff @(posedge clk) begin
    if (sys_rst || !level) begin
      count <= 4'h0;
      fired <= 1'b0;
    end else if (count != HOLD[3:0]) begin
      count <= count + 4'h1;
    end else begin
      fired <= 1'b1;
    end
  end

  assign event_pulse = level && (count == HOLD[3:0]) && !fired;
endmodule

// file: include/pin_irq_led_pkg.sv
package pin_irq_led_pkg;
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] LED_PIN_CONFIGURATION_OFFSET   = 12'h01bc;
  localparam logic [11:0] PIN_IRQ_OFFSET   = 12'h01e8;
  localparam logic [11:0] SYS_STATUS_OFFSET = 12'h0100;
  localparam logic [11:0] SYS_ENABLE_OFFSET = 12'h0104;
  localparam logic [11:0] PIN_POL_OFFSET   = 12'h0108;
  localparam int          STATUS_LSB       = 0;
  localparam int          ENABLE_LSB       = 16;
  localparam int          SELECT_LSB       = 0;
  localparam int          INDICATION_LSB   = 8;
  localparam int          SYS_PIN_BIT      = 12;
  localparam logic [11:0] ENABLE_RESET     = 12'h0000;
  localparam logic [11:0] POL_RESET        = 12'h0fff;
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          MIN_PULSE_NS     = 40;
  // Longer than 40 ns: cycles covering it, plus one so the level must outlast it
  localparam int          MIN_PULSE_CYC    = MIN_PULSE_NS / CLK_PERIOD_NS + 1;
  localparam int          BLINK_DIV        = 5000000;
  typedef enum logic [1:0] {IND_LINK, IND_ACT, IND_BLINK, IND_OFF} indication_t;
endpackage

// file: tb/gpio_interrupt_and_led_select_test.sv
module gpio_interrupt_and_led_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_irq_led_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic        loader_valid = 1'b0;
  logic [1:0]  loader_indication = 2'h0;
  logic [7:0]  loader_pin_select = 8'h00;
  logic [11:0] pin_req = 12'h000;
  logic [7:0]  led_link = 8'h00;
  logic [7:0]  gpio_out = 8'h5a;
  logic [11:0] pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  led_mode;
  logic        irq;
  int          failures = 0;
  int          compares = 0;
  row_t        rows [5] = '{'{LED_PIN_CONFIGURATION_OFFSET, 32'hffff_ffff, 32'h0000_03ff},
    '{PIN_IRQ_OFFSET, 32'h0fff_0fff, 32'h0fff_0000}, '{12'h0ff0, 32'hffff_ffff, 32'h0},
    '{PIN_IRQ_OFFSET, 32'h0001_0000, 32'h0001_0000}, '{SYS_ENABLE_OFFSET, 32'h0, 32'h0}};
  // Clock at 50 MHz
  always #10 clk = ~clk;
  gpio_interrupt_and_led_select #(.BLINK_N(4)) uut (.clk, .sys_rst, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .indication_select_strap(2'h2), .pin_select_strap(8'ha5),
    .loader_valid, .loader_indication, .loader_pin_select, .pin_in,
    .led_link, .led_activity(8'h00), .gpio_out, .pin_out, .led_mode, .irq);
  pin_board board (.pin_req, .pin_in);
  task give_verdict;
    $display("Counts: %0d failures of %0d compares", failures, compares);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Optional write, then optional read in the very next cycle
  task xfer(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= r;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    if (r) chk(rdata, e);
  endtask
  // Hold pins for n cycles, then give the filter time to settle
  task pulse(input logic [11:0] p, input int n);
    @(posedge clk);
    pin_req <= p;
    repeat (n) @(posedge clk);
    pin_req <= 12'h000;
    repeat (8) @(posedge clk);
  endtask
  task wait_irq;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    if (irq !== 1'b1) begin
      failures++;
      give_verdict;
    end
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, 1'b1, LED_PIN_CONFIGURATION_OFFSET, 32'h0, 32'h0000_02a5);
    xfer(1'b0, 1'b1, PIN_IRQ_OFFSET, 32'h0, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) xfer(1'b1, 1'b1, rows[i].a, rows[i].d, rows[i].e);
    $display("test rows done");
    pulse(12'h001, 2);
    xfer(1'b0, 1'b1, PIN_IRQ_OFFSET, 32'h0, 32'h0001_0000);
    pulse(12'h003, 6);
    xfer(1'b0, 1'b1, PIN_IRQ_OFFSET, 32'h0, 32'h0001_0003);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    xfer(1'b1, 1'b0, SYS_ENABLE_OFFSET, 32'h0000_1000, 32'h0);
    wait_irq;
    xfer(1'b0, 1'b1, SYS_STATUS_OFFSET, 32'h0, 32'h0000_1000);
    xfer(1'b1, 1'b0, PIN_IRQ_OFFSET, 32'h0001_0001, 32'h0);
    xfer(1'b0, 1'b1, PIN_IRQ_OFFSET, 32'h0, 32'h0001_0002);
    xfer(1'b0, 1'b1, SYS_STATUS_OFFSET, 32'h0, 32'h0000_1000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test pin events done");
    @(posedge clk);
    loader_valid <= 1'b1;
    loader_indication <= 2'h1;
    loader_pin_select <= 8'h3c;
    @(posedge clk);
    loader_valid <= 1'b0;
    xfer(1'b0, 1'b1, LED_PIN_CONFIGURATION_OFFSET, 32'h0, 32'h0000_013c);
    $display("test loader done");
    led_link <= 8'hff;
    repeat (3) @(posedge clk);
    #1;
    chk({24'h00_0000, pin_out}, 32'h0000_007e);
    chk({24'h00_0000, led_mode}, 32'h0000_003c);
    $display("test outputs done");
    give_verdict;
  end
endmodule

// file: tb/gpio_irq_sva.sv
module gpio_irq_sva
  import pin_irq_led_pkg::*;
#(
  parameter int LEDS = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rdata,
  // Straps, loader and pins
  input wire logic [7:0]        pin_select_strap,
  input wire logic              loader_valid,
  input wire logic [7:0]        loader_pin_select,
  input wire logic [LEDS-1:0]   gpio_out,
  input wire logic [LEDS-1:0]   pin_out,
  input wire logic [LEDS-1:0]   led_mode,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wd1;
  logic [31:0] wd2;
  // Write data two cycles back, for read-back checks
  always_ff @(posedge clk) begin
    wd1 <= wdata;
    wd2 <= wd1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
    else $error("rdata not zero outside read answer");
  a_gpio_pass: assert property (!$past(sys_rst) |->
    ((pin_out ^ $past(gpio_out)) & ~led_mode) == {LEDS{1'b0}})
    else $error("general purpose pin lost its data");
  a_strap_latch: assert property ($fell(sys_rst) |->
    ##2 led_mode == $past(pin_select_strap, 2))
    else $error("pin select strap not latched");
  a_loader_load: assert property (loader_valid |->
    ##2 led_mode == $past(loader_pin_select, 2))
    else $error("loader value not applied");
  a_cfg_readback: assert property (wr_en && addr == LED_PIN_CONFIGURATION_OFFSET && !loader_valid
    && !$past(sys_rst) ##1 rd_en && addr == LED_PIN_CONFIGURATION_OFFSET
    |=> rdata == {22'h00_0000, wd2[9:0]})
    else $error("LED configuration read-back wrong");
  a_en_readback: assert property (wr_en && addr == PIN_IRQ_OFFSET
    ##1 rd_en && addr == PIN_IRQ_OFFSET
    |=> rdata[31:12] == {4'h0, wd2[27:16], 4'h0})
    else $error("enable read-back wrong");
  a_enable_gate: assert property (wr_en && addr == SYS_ENABLE_OFFSET && !wdata[12]
    |=> !irq)
    else $error("irq without system enable");
  a_irq_reset: assert property ($fell(sys_rst) |-> !irq)
    else $error("irq high after reset");
  c_loader: cover property (loader_valid);
  c_irq: cover property ($rose(irq));
  c_sys_read: cover property (rd_en && addr == SYS_STATUS_OFFSET);
endmodule
bind gpio_interrupt_and_led_select gpio_irq_sva #(.LEDS(LEDS)) chk (.clk, .sys_rst,
  .addr, .wdata, .wr_en, .rd_en, .rdata, .pin_select_strap, .loader_valid,
  .loader_pin_select, .gpio_out, .pin_out, .led_mode, .irq);

// file: tb/pin_board.sv
// Board pins around the port, driven to the levels the bench asks for
module pin_board (
  // Requested levels
  input  wire logic [11:0] pin_req,
  // Pins seen by the port
  output logic      [11:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Skew keeps the pins asynchronous to the sampling edge
  initial pin_in = 12'h000;
  always @(pin_req) pin_in <= #7 pin_req;
endmodule
